// ### logic/smr_receiver.sv
// synchronous master receive path with an AXI4-Lite register slave
// assumes one 125 MHz clock, serial data pin asynchronous to it
`timescale 1ns/1ps
module smr_receiver (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic [smr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [smr_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [smr_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [smr_pkg::DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic                       serial_data_pin_in,
    output logic                            serial_data_pin_out,
    output logic                            serial_data_pin_oe,
    output logic                            shift_clock_pin_out,
    output logic                            shift_clock_pin_oe,
    output logic                            rx_irq
);
    import smr_pkg::*;

    function automatic logic [3:0] char_bits(input logic nine);
        char_bits = nine ? BITS_NINE : BITS_EIGHT;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    logic [CTL_W-1:0]   ctrl;
    logic [7:0]         div_low;
    logic [7:0]         div_high;
    logic               overrun;
    logic               continuous_receive_enable_d;
    smr_state_t         state;
    logic [15:0]        div_cnt;
    logic               sck;
    logic [3:0]         bit_cnt;
    logic [CHAR_W-1:0]  shreg;
    logic [2:0]         din_sync;
    logic               din;
    logic               aw_hold;
    logic [ADDR_W-1:0]  aw_addr;
    logic               w_hold;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               q_in_ready;
    logic               q_out_valid;
    logic [CHAR_W-1:0]  q_head;

    wire serial_port_enable     = ctrl[CTL_SERIAL_PORT_ENABLE];
    wire single_receive_enable     = ctrl[CTL_SINGLE_RECEIVE_ENABLE];
    wire continuous_receive_enable     = ctrl[CTL_CONTINUOUS_RECEIVE_ENABLE];
    wire nine_sel = ctrl[CTL_NINE];
    wire master_on = serial_port_enable & ctrl[CTL_SYNC] & ctrl[CTL_CLOCK_SOURCE_MASTER_SELECT];
    wire run       = master_on & (single_receive_enable | continuous_receive_enable) & ~overrun;

    // in sync mode both speed options give the same clock; only the
    // wide option changes which divisor bits count
    wire [15:0] divisor = ctrl[CTL_WIDE] ? {div_high, div_low}
                                         : {8'h00, div_low};
    wire half_tick  = (state == SMR_SHIFT) && (div_cnt == 16'h0000);
    wire fall       = half_tick & sck;
    wire last_bit   = fall && (bit_cnt == char_bits(nine_sel) - 4'h1);
    wire [CHAR_W-1:0] next_shreg = {din, shreg[CHAR_W-1:1]};
    wire [CHAR_W-1:0] next_char  = nine_sel ? next_shreg
                                            : {1'b0, next_shreg[8:1]};
    wire push       = last_bit & q_in_ready;
    wire set_ovr    = last_bit & ~q_in_ready;
    wire single_receive_enable_done  = last_bit & single_receive_enable;
    wire stop_after = last_bit & single_receive_enable & ~continuous_receive_enable;

    wire aw_fire    = s_axi_awvalid & s_axi_awready;
    wire w_fire     = s_axi_wvalid & s_axi_wready;
    wire ar_fire    = s_axi_arvalid & s_axi_arready;
    wire do_write   = aw_hold & w_hold & ~s_axi_bvalid;
    wire wr_ctrl    = do_write && (aw_addr == OFF_CONTROL);
    wire wr_low     = do_write && (aw_addr == OFF_DIV_LOW);
    wire wr_high    = do_write && (aw_addr == OFF_DIV_HIGH);
    wire wr_known   = wr_ctrl | wr_low | wr_high | (aw_addr == OFF_STATUS)
                    | (aw_addr == OFF_DATA);
    wire rd_data    = ar_fire && (s_axi_araddr == OFF_DATA);
    wire pop        = rd_data & q_out_valid;
    wire [31:0] ctrl_merged = merge({23'h0, ctrl}, w_data, w_strb);
    wire [31:0] low_merged  = merge({24'h0, div_low}, w_data, w_strb);
    wire [31:0] high_merged = merge({24'h0, div_high}, w_data, w_strb);

    // ninth bit only shown in nine-bit mode
    wire [31:0] status_word = {28'h0, (state == SMR_SHIFT), q_out_valid,
                               overrun, q_head[8] & nine_sel};
    wire [31:0] data_word   = {24'h0, q_head[7:0]};
    wire        rd_known;
    wire [31:0] rd_word;
    assign rd_known = (s_axi_araddr == OFF_CONTROL)
                    | (s_axi_araddr == OFF_DIV_LOW)
                    | (s_axi_araddr == OFF_DIV_HIGH)
                    | (s_axi_araddr == OFF_STATUS) | rd_data;
    assign rd_word  = (s_axi_araddr == OFF_CONTROL)  ? {23'h0, ctrl} :
                      (s_axi_araddr == OFF_DIV_LOW)  ? {24'h0, div_low} :
                      (s_axi_araddr == OFF_DIV_HIGH) ? {24'h0, div_high} :
                      (s_axi_araddr == OFF_STATUS)   ? status_word :
                      rd_data                        ? data_word : 32'h0;

    assign s_axi_awready       = ~aw_hold & ~s_axi_bvalid;
    assign s_axi_wready        = ~w_hold & ~s_axi_bvalid;
    assign s_axi_arready       = ~s_axi_rvalid;
    assign serial_data_pin_out = 1'b0;
    assign serial_data_pin_oe  = 1'b0;
    assign shift_clock_pin_out = sck;
    assign shift_clock_pin_oe  = master_on;
    assign rx_irq = q_out_valid & ctrl[CTL_RXIE];

    smr_fifo #(
        .WIDTH (CHAR_W),
        .DEPTH (QUEUE_DEPTH)
    ) u_queue (
        .clock     (clock),
        .rst       (rst),
        .flush     (~serial_port_enable),
        .in_data   (next_char),
        .in_valid  (last_bit),
        .in_ready  (q_in_ready),
        .out_data  (q_head),
        .out_valid (q_out_valid),
        .out_ready (rd_data)
    );

    // pin synchroniser: only the agreeing later stages update the bit
    always_ff @(posedge clock) begin
        if (rst) begin
            din_sync <= 3'h0;
            din      <= 1'b0;
        end else begin
            din_sync <= {din_sync[1:0], serial_data_pin_in};
            if (din_sync[1] == din_sync[2]) din <= din_sync[2];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl     <= CTL_RESET;
            div_low  <= DIV_RESET;
            div_high <= DIV_RESET;
        end else begin
            if (wr_ctrl) ctrl <= ctrl_merged[CTL_W-1:0];
            if (wr_low) div_low <= low_merged[7:0];
            if (wr_high) div_high <= high_merged[7:0];
            if (single_receive_enable_done) ctrl[CTL_SINGLE_RECEIVE_ENABLE] <= 1'b0;
        end
    end

    // overrun: set wins; cleared by port disable, falling continuous
    // enable, or a data read while continuous enable is off
    always_ff @(posedge clock) begin
        if (rst) begin
            overrun <= 1'b0;
            continuous_receive_enable_d  <= 1'b0;
        end else begin
            continuous_receive_enable_d <= continuous_receive_enable;
            if (set_ovr) overrun <= 1'b1;
            else if (!serial_port_enable || (continuous_receive_enable_d && !continuous_receive_enable) || (rd_data && !continuous_receive_enable))
                overrun <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state   <= SMR_IDLE;
            div_cnt <= 16'h0000;
            sck     <= 1'b0;
            bit_cnt <= 4'h0;
            shreg   <= '0;
        end else begin
            case (state)
                SMR_IDLE: begin
                    sck     <= 1'b0;
                    bit_cnt <= 4'h0;
                    div_cnt <= divisor;
                    if (run) state <= SMR_SHIFT;
                end
                SMR_SHIFT: begin
                    if (!run) begin
                        // partial character dropped, clock parked low
                        state <= SMR_IDLE;
                        sck   <= 1'b0;
                    end else if (half_tick) begin
                        div_cnt <= divisor;
                        sck     <= ~sck;
                        if (sck) begin
                            shreg   <= next_shreg;
                            bit_cnt <= last_bit ? 4'h0 : bit_cnt + 4'h1;
                            if (stop_after || set_ovr) state <= SMR_IDLE;
                        end
                    end else begin
                        div_cnt <= div_cnt - 16'h0001;
                    end
                end
                default: state <= SMR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            aw_hold      <= 1'b0;
            aw_addr      <= '0;
            w_hold       <= 1'b0;
            w_data       <= 32'h0;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    a_start_needs_master: assert property (@(posedge clock) disable iff (rst)
        (state == SMR_IDLE) ##1 (state == SMR_SHIFT) |-> $past(master_on))
        else $error("reception started without master setup");

    a_sck_idle_low: assert property (@(posedge clock) disable iff (rst)
        (state == SMR_IDLE) ##1 (state == SMR_IDLE) |-> !sck)
        else $error("shift clock not parked low while idle");

    a_abort_stops_clock: assert property (@(posedge clock) disable iff (rst)
        (state == SMR_SHIFT) && !(single_receive_enable | continuous_receive_enable) |=> (state == SMR_IDLE) && !sck)
        else $error("clock kept running after receive disable");

    a_single_self_clear: assert property (@(posedge clock) disable iff (rst)
        last_bit && single_receive_enable && !wr_ctrl |=> !ctrl[CTL_SINGLE_RECEIVE_ENABLE])
        else $error("single receive enable not cleared");

    a_overrun_on_full: assert property (@(posedge clock) disable iff (rst)
        last_bit && !q_in_ready |=> overrun ##1 (state == SMR_IDLE))
        else $error("full queue did not raise overrun");

    a_flag_after_char: assert property (@(posedge clock) disable iff (rst)
        push && !rd_data |=> q_out_valid && (rx_irq == ctrl[CTL_RXIE]))
        else $error("complete flag missing after a character");

    a_port_off_clears: assert property (@(posedge clock) disable iff (rst)
        !serial_port_enable && !set_ovr |=> !overrun && !q_out_valid)
        else $error("port disable did not reset the receiver");

    a_bits_per_char: assert property (@(posedge clock) disable iff (rst)
        fall |-> bit_cnt < char_bits(nine_sel))
        else $error("bit count beyond character length");

    a_read_answers: assert property (@(posedge clock) disable iff (rst)
        ar_fire && (s_axi_araddr == OFF_DATA) |=>
            s_axi_rvalid && (s_axi_rdata == {24'h0, $past(q_head[7:0])}))
        else $error("data read did not return the queue head");
endmodule

// ### logic/smr_pkg.sv
// constants for the synchronous master receiver: register map, fields,
// reset values and receive queue shape; shared by the receiver and testbench
package smr_pkg;
    localparam int unsigned ADDR_W        = 5;
    localparam int unsigned DATA_W        = 32;
    localparam logic [4:0]  OFF_CONTROL   = 5'h00;
    localparam logic [4:0]  OFF_DIV_LOW   = 5'h04;
    localparam logic [4:0]  OFF_DIV_HIGH  = 5'h08;
    localparam logic [4:0]  OFF_STATUS    = 5'h0c;
    localparam logic [4:0]  OFF_DATA      = 5'h10;

    // control register fields
    localparam int unsigned CTL_W         = 9;
    localparam int unsigned CTL_SERIAL_PORT_ENABLE      = 0;
    localparam int unsigned CTL_SYNC      = 1;
    localparam int unsigned CTL_CLOCK_SOURCE_MASTER_SELECT      = 2;
    localparam int unsigned CTL_SINGLE_RECEIVE_ENABLE      = 3;
    localparam int unsigned CTL_CONTINUOUS_RECEIVE_ENABLE      = 4;
    localparam int unsigned CTL_NINE      = 5;
    localparam int unsigned CTL_RXIE      = 6;
    localparam int unsigned CTL_HISPEED   = 7;
    localparam int unsigned CTL_WIDE      = 8;
    localparam logic [8:0]  CTL_RESET     = 9'h000;
    localparam logic [7:0]  DIV_RESET     = 8'h00;

    // status register fields
    localparam int unsigned STS_NINTH     = 0;
    localparam int unsigned STS_OVERRUN   = 1;
    localparam int unsigned STS_COMPLETE  = 2;
    localparam int unsigned STS_BUSY      = 3;

    localparam int unsigned CHAR_W        = 9;
    localparam int unsigned QUEUE_DEPTH   = 2;
    localparam logic [3:0]  BITS_EIGHT    = 4'h8;
    localparam logic [3:0]  BITS_NINE     = 4'h9;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [0:0] {
        SMR_IDLE  = 1'b0,
        SMR_SHIFT = 1'b1
    } smr_state_t;
endpackage

// ### logic/smr_fifo.sv
// small receive queue held in flip-flops, valid/ready on both sides
// assumes one clock; flush empties it in one cycle
`timescale 1ns/1ps
module smr_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    wire do_push = in_valid & in_ready;
    wire do_pop  = out_valid & out_ready;

    assign in_ready  = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clock) begin
        if (do_push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) wr_ptr <= bump(wr_ptr);
            if (do_pop) rd_ptr <= bump(rd_ptr);
            count <= count + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end

    a_fifo_depth_bound: assert property (@(posedge clock) disable iff (rst)
        count <= (PW+1)'(DEPTH))
        else $error("queue count above depth");
endmodule

// ### testbench/smr_slave_model.sv
// serial slave that feeds characters to the master receiver
// assumes the shift clock is sampled on the bench clock; restart realigns it
`timescale 1ns/1ps
module smr_slave_model (
    input  wire logic       clock,
    input  wire logic       restart,
    input  wire logic       sck,
    input  wire logic [8:0] char_a,
    input  wire logic [8:0] char_b,
    input  wire logic       nine,
    output logic            data
);
    logic       sck_d;
    logic [3:0] idx;
    logic       pick_b;
    logic [2:0] hold;
    logic [8:0] cur;
    logic [3:0] last_idx;

    assign cur      = pick_b ? char_b : char_a;
    assign last_idx = nine ? 4'h8 : 4'h7;

    // data moves on the leading edge, then goes stale after its hold time
    always @(posedge clock) begin
        sck_d <= sck;
        if (restart) begin
            idx    <= 4'h0;
            pick_b <= 1'b0;
            hold   <= 3'h0;
            data   <= 1'b1;
        end else if (sck && !sck_d) begin
            data <= cur[idx];
            hold <= 3'h0;
            if (idx == last_idx) begin
                idx    <= 4'h0;
                pick_b <= !pick_b;
            end else begin
                idx <= idx + 4'h1;
            end
        end else if (!sck && sck_d) begin
            hold <= 3'h5;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
            if (hold == 3'h1) data <= ~data;
        end
    end
endmodule

// ### testbench/sync_master_serial_receiver_test.sv
// bench for the synchronous master receiver over AXI4-Lite registers
// assumes the slave model on the link; divisor 9 gives a 160 ns shift clock
`timescale 1ns/1ps
module sync_master_serial_receiver_test;
    import smr_pkg::*;
    localparam logic [31:0] C_BASE = 32'h7;
    localparam logic [31:0] C_ONE  = 32'h8;
    localparam logic [31:0] C_CONT = 32'h10;
    localparam logic [31:0] C_NINE = 32'h20;
    localparam logic [31:0] C_IE   = 32'h40;
    localparam logic [31:0] C_WIDE = 32'h100;
    localparam logic [31:0] S_CMP  = 32'h1 << STS_COMPLETE;
    localparam logic [31:0] S_OVR  = 32'h1 << STS_OVERRUN;
    logic        clock, rst, restart, nine, sck_q;
    logic [8:0]  char_a, char_b;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, sdata;
    logic        sck, sck_oe, data_oe, data_out, rx_irq;
    int          fails, comparisons, rises, base;
    time         gap, last_rise;

    smr_receiver dut_u (
        .clock(clock), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_data_pin_in(sdata), .serial_data_pin_out(data_out),
        .serial_data_pin_oe(data_oe), .shift_clock_pin_out(sck),
        .shift_clock_pin_oe(sck_oe), .rx_irq(rx_irq)
    );
    smr_slave_model slave_u (
        .clock(clock), .restart(restart), .sck(sck), .char_a(char_a),
        .char_b(char_b), .nine(nine), .data(sdata)
    );

    always #4 clock = ~clock;

    // shift clock edges counted where the design's outputs are settled
    always @(negedge clock) begin
        sck_q <= sck;
        if (sck && !sck_q) begin
            rises     <= rises + 1;
            gap       <= $time - last_rise;
            last_rise <= $time;
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic give_up();
        fails++;
        conclude();
    endtask

    task automatic axi_write(input logic [4:0] a, input logic [31:0] v,
                             output logic [1:0] resp);
        int   n;
        logic hs_aw, hs_w, done;
        @(posedge clock);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        done = 1'b0;
        for (n = 0; n < 100 && !done; n++) begin
            @(negedge clock);
            hs_aw = awvalid && awready;
            hs_w  = wvalid && wready;
            done  = bvalid;
            resp  = bresp;
            @(posedge clock);
            if (hs_aw) awvalid <= 1'b0;
            if (hs_w) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
        if (!done) give_up();
    endtask

    task automatic axi_read(input logic [4:0] a, output logic [31:0] v,
                            output logic [1:0] resp);
        int   n;
        logic hs, done;
        @(posedge clock);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        done = 1'b0;
        for (n = 0; n < 100 && !done; n++) begin
            @(negedge clock);
            hs   = arvalid && arready;
            done = rvalid;
            v    = rdata;
            resp = rresp;
            @(posedge clock);
            if (hs) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        if (!done) give_up();
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        logic [1:0] resp;
        axi_write(a, v, resp);
        check("write_resp", {30'h0, resp}, {30'h0, RESP_OKAY});
    endtask

    task automatic rd_chk(input string name, input logic [4:0] a,
                          input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0]  resp;
        axi_read(a, v, resp);
        check(name, v, exp);
    endtask

    task automatic wait_status(input logic [31:0] mask);
        logic [31:0] v;
        logic [1:0]  resp;
        int          n;
        v = '0;
        for (n = 0; n < 400 && (v & mask) == '0; n++) begin
            axi_read(OFF_STATUS, v, resp);
        end
        if ((v & mask) == '0) give_up();
    endtask

    task automatic new_frame(input logic [8:0] a, input logic [8:0] b,
                             input logic n9);
        @(posedge clock);
        restart <= 1'b1;
        char_a  <= a;
        char_b  <= b;
        nine    <= n9;
        @(posedge clock);
        restart <= 1'b0;
        base = rises;
    endtask

    initial begin
        {clock, rst, restart, nine, sck_q} = 5'h0c;
        {char_a, char_b} = 18'h0;
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready, fails, comparisons, rises, base} = '0;
        {gap, last_rise} = '0;
        wstrb = 4'hf;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        restart <= 1'b0;
        @(negedge clock);
        check("sck_oe_reset", {31'h0, sck_oe}, 32'h0);
        rd_chk("ctl_reset", OFF_CONTROL, 32'h0);
        rd_chk("sts_reset", OFF_STATUS, 32'h0);
        wr(OFF_DIV_LOW, 32'h9);
        wr(OFF_DIV_HIGH, 32'h1);
        wr(OFF_CONTROL, C_BASE);
        @(negedge clock);
        check("sck_oe", {31'h0, sck_oe}, 32'h1);
        check("data_oe", {31'h0, data_oe}, 32'h0);
        check("data_out", {31'h0, data_out}, 32'h0);
        axi_read(5'h14, d, r);
        check("unmapped_rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        check("unmapped_rdata", d, 32'h0);
        axi_write(5'h18, 32'h1, r);
        check("unmapped_bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        // one character each in eight and nine bit form
        for (int k = 0; k < 2; k++) begin
            new_frame(k ? 9'h15a : 9'h0c3, 9'h0, k[0]);
            wr(OFF_CONTROL, C_BASE | C_ONE | C_IE | (k ? C_NINE : 0));
            wait_status(S_CMP);
            repeat (40) @(posedge clock);
            @(negedge clock);
            check("rise_count", 32'(rises - base), k ? 32'h9 : 32'h8);
            check("sck_period", 32'(gap), 32'd160);
            check("irq_on", {31'h0, rx_irq}, 32'h1);
            rd_chk("single_cleared", OFF_CONTROL, C_BASE | C_IE | (k ? C_NINE : 0));
            rd_chk("sts_ninth", OFF_STATUS, S_CMP | 32'(k));
            rd_chk("data_low", OFF_DATA, k ? 32'h5a : 32'hc3);
            rd_chk("sts_empty", OFF_STATUS, 32'h0);
            @(negedge clock);
            check("irq_off", {31'h0, rx_irq}, 32'h0);
        end
        // third character into a full queue, cleared two ways
        for (int m = 0; m < 2; m++) begin
            new_frame(9'h011, 9'h022, 1'b0);
            wr(OFF_CONTROL, C_BASE | C_CONT | C_ONE);
            wait_status(S_OVR);
            base = rises;
            repeat (60) @(negedge clock);
            check("overrun_halt", 32'(rises - base), 32'h0);
            rd_chk("sts_overrun", OFF_STATUS, S_OVR | S_CMP);
            rd_chk("both_cont", OFF_CONTROL, C_BASE | C_CONT);
            wr(OFF_CONTROL, m ? 32'h0 : C_BASE);
            rd_chk("sts_cleared", OFF_STATUS, m ? 32'h0 : S_CMP);
            if (m == 0) begin
                rd_chk("queue_first", OFF_DATA, 32'h11);
                rd_chk("queue_second", OFF_DATA, 32'h22);
            end
        end
        // continuous reception dropped in mid character
        wr(OFF_CONTROL, C_BASE);
        new_frame(9'h0ff, 9'h0ff, 1'b0);
        wr(OFF_CONTROL, C_BASE | C_CONT);
        for (int n = 0; n < 1000 && rises - base < 3; n++) @(negedge clock);
        if (rises - base < 3) give_up();
        rd_chk("sts_busy", OFF_STATUS, 32'h1 << STS_BUSY);
        wr(OFF_CONTROL, C_BASE);
        repeat (2) @(negedge clock);
        base = rises;
        check("abort_sck_low", {31'h0, sck}, 32'h0);
        repeat (60) @(negedge clock);
        check("abort_halt", 32'(rises - base), 32'h0);
        rd_chk("abort_discard", OFF_STATUS, 32'h0);
        // wide divisor joins the high half: 2 * (0x109 + 1) clocks
        wr(OFF_CONTROL, C_BASE | C_WIDE);
        wr(OFF_CONTROL, C_BASE | C_WIDE | C_CONT);
        base = rises;
        for (int n = 0; n < 2000 && rises - base < 2; n++) @(negedge clock);
        if (rises - base < 2) give_up();
        check("wide_period", 32'(gap), 32'd4256);
        wr(OFF_CONTROL, C_BASE);
        conclude();
    end
endmodule
